/* rtl/flash_host.sv */
// Host controller that drives a parallel NOR flash through its pins.
// Assumes the flash's pins are wired directly; the wire level is resolved outside.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_host (
    input  wire logic                        core_clk_i,
    input  wire logic                        reset_n_i,
    input  wire logic                        req_valid_i,
    output logic                             req_ready_o,
    input  wire flash_host_pkg::host_op_e    req_op_i,
    input  wire flash_host_pkg::flash_addr_t req_addr_i,
    input  wire flash_host_pkg::flash_data_t req_data_i,
    input  wire logic                        byte_mode_i,
    input  wire logic                        protect_alt_i,
    output logic                             resp_valid_o,
    output flash_host_pkg::flash_data_t      resp_data_o,
    output logic                             bypass_active_o,
    output logic                             aborted_o,
    output flash_host_pkg::flash_addr_t      addr_o,
    output logic                             top_data_or_low_address_o,
    input  wire flash_host_pkg::flash_data_t dq_i,
    output flash_host_pkg::flash_data_t      dq_o,
    output logic                             dq_oe_o,
    output logic                             chip_select_n_o,
    output logic                             output_gate_n_o,
    output logic                             write_strobe_n_o,
    output logic                             width_select_n_o,
    output logic                             hardware_clear_n_o,
    output logic                             clear_elevated_o,
    output logic                             id_voltage_address_elevated_o,
    output logic                             output_gate_elevated_o,
    input  wire logic                        ready_busy_n_i
);
    import flash_host_pkg::*;
    typedef enum logic [2:0] {H_IDLE, H_SEQ, H_BUS, H_RESET_PULSE, H_RESET_WAIT, H_RECOVER} host_state_e;
    localparam logic [15:0] RP_CYC    = 16'(`T_RP_CYC);
    localparam logic [15:0] RH_CYC    = 16'(`T_RH_CYC);
    localparam logic [15:0] READY_CYC = 16'(`T_READY_CYC);

    // Number of bus cycles (steps) in the command sequence of each operation
    function automatic logic [2:0] seq_len(input host_op_e op);
        case (op)
            OP_PROGRAM, OP_SECTOR_ERASE_MORE: seq_len = (op == OP_PROGRAM) ? 3'd4 : 3'd1;
            OP_BYPASS_PROGRAM:                seq_len = 3'd2;
            OP_BYPASS_ENTER, OP_IDENTIFY:     seq_len = 3'd3;
            OP_SECTOR_ERASE, OP_CHIP_ERASE:   seq_len = 3'd6;
            OP_READ, OP_WRITE, OP_READ_RESET: seq_len = 3'd1;
            OP_PROTECT:                       seq_len = 3'd2;
            default:                          seq_len = 3'd0;
        endcase
    endfunction : seq_len

    host_state_e state, next_state;
    host_op_e    op, next_op;
    flash_addr_t addr, next_addr;
    flash_data_t data, next_data;
    logic [2:0]  step, next_step;
    logic [15:0] timer, next_timer;
    logic [15:0] wait_cnt, next_wait_cnt;
    logic        bypass, next_bypass;
    logic        aborted, next_aborted;
    logic        busy_seen, next_busy_seen;
    logic        resp_valid, next_resp_valid;
    logic        byte_mode, next_byte_mode;
    logic        alt, next_alt;

    logic        cyc_start, cyc_write, cyc_ready, cyc_done;
    flash_addr_t cyc_addr;
    flash_data_t cyc_wdata, cyc_rdata, bus_dq;

    // Pick the address, data and direction of the current step
    always_comb begin
        cyc_addr  = addr;
        cyc_wdata = data;
        cyc_write = 1'b1;
        case (op)
            OP_READ: cyc_write = 1'b0;
            OP_PROTECT: begin
                cyc_addr  = (addr & ~`PROT_ADDR_MASK) | `PROT_ADDR_VALUE;
                cyc_write = (step == 3'd0);
            end
            OP_WRITE: cyc_write = 1'b1;
            default: begin
                if (op == OP_BYPASS_PROGRAM) begin
                    cyc_addr  = (step == 3'd0) ? `UNLOCK1_ADDR : addr;
                    cyc_wdata = (step == 3'd0) ? `CMD_PROGRAM : data;
                end else if (op == OP_SECTOR_ERASE_MORE) begin
                    cyc_wdata = `CMD_SECTOR_ERASE;
                end else if (op == OP_PROGRAM && step == 3'd3) begin
                    cyc_wdata = data;
                end else if (step == 3'd0 || step == 3'd3) begin
                    cyc_addr  = `UNLOCK1_ADDR;
                    cyc_wdata = `UNLOCK1_DATA;
                end else if (step == 3'd1 || step == 3'd4) begin
                    cyc_addr  = `UNLOCK2_ADDR;
                    cyc_wdata = `UNLOCK2_DATA;
                end else if (step == 3'd2) begin
                    cyc_addr = `UNLOCK1_ADDR;
                    case (op)
                        OP_PROGRAM:      cyc_wdata = `CMD_PROGRAM;
                        OP_BYPASS_ENTER: cyc_wdata = `CMD_BYPASS_ENTER;
                        OP_IDENTIFY:     cyc_wdata = `CMD_IDENTIFY;
                        default:         cyc_wdata = `CMD_ERASE_SETUP;
                    endcase
                end else if (op == OP_CHIP_ERASE) begin
                    cyc_addr  = `UNLOCK1_ADDR;
                    cyc_wdata = `CMD_CHIP_ERASE;
                end else begin
                    cyc_wdata = `CMD_SECTOR_ERASE;
                end
                if (op == OP_READ_RESET) begin
                    cyc_wdata = `CMD_READ_RESET;
                end
            end
        endcase
    end

    always_comb begin
        next_state      = state;
        next_op         = op;
        next_addr       = addr;
        next_data       = data;
        next_step       = step;
        next_timer      = timer;
        next_bypass     = bypass;
        next_aborted    = aborted;
        next_busy_seen  = busy_seen;
        next_resp_valid = 1'b0;
        next_byte_mode  = byte_mode;
        next_alt        = alt;
        cyc_start       = 1'b0;
        next_wait_cnt   = (state == H_RESET_WAIT) ? wait_cnt + 16'h0001 : 16'h0000;
        case (state)
            H_IDLE: begin
                if (req_valid_i) begin
                    next_op        = req_op_i;
                    next_addr      = req_addr_i;
                    next_data      = req_data_i;
                    next_step      = 3'd0;
                    next_byte_mode = byte_mode_i;
                    next_alt       = protect_alt_i;
                    next_state     = (req_op_i == OP_HW_RESET) ? H_RESET_PULSE : H_SEQ;
                    next_timer     = RP_CYC;
                    next_aborted   = 1'b0;
                    next_busy_seen = 1'b0;
                end
            end
            H_SEQ: begin
                if (cyc_ready) begin
                    cyc_start  = 1'b1;
                    next_state = H_BUS;
                end
            end
            H_BUS: begin
                if (cyc_done) begin
                    if (step + 3'd1 >= seq_len(op)) begin
                        next_state      = H_IDLE;
                        next_resp_valid = 1'b1;
                        if (op == OP_BYPASS_ENTER) begin
                            next_bypass = 1'b1;
                        end else if (op == OP_READ_RESET) begin
                            next_bypass = 1'b0;
                        end
                    end else begin
                        next_step  = step + 3'd1;
                        next_state = H_SEQ;
                    end
                end
            end
            H_RESET_PULSE: begin
                if (!ready_busy_n_i) begin
                    next_busy_seen = 1'b1;
                end
                if (timer > 16'h0001) begin
                    next_timer = timer - 16'h0001;
                end else begin
                    next_state = H_RESET_WAIT;
                    next_timer = READY_CYC;
                end
            end
            H_RESET_WAIT: begin
                if (ready_busy_n_i || timer <= 16'h0001) begin
                    next_state = H_RECOVER;
                    next_timer = RH_CYC;
                end else begin
                    next_timer = timer - 16'h0001;
                end
            end
            default: begin
                if (timer > 16'h0001) begin
                    next_timer = timer - 16'h0001;
                end else begin
                    next_state      = H_IDLE;
                    next_bypass     = 1'b0;
                    next_aborted    = busy_seen;
                    next_resp_valid = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state      <= H_IDLE;
            op         <= OP_READ;
            addr       <= 18'h00000;
            data       <= 16'h0000;
            step       <= 3'd0;
            timer      <= 16'h0000;
            wait_cnt   <= 16'h0000;
            bypass     <= 1'b0;
            aborted    <= 1'b0;
            busy_seen  <= 1'b0;
            resp_valid <= 1'b0;
            byte_mode  <= 1'b0;
            alt        <= 1'b0;
        end else begin
            state      <= next_state;
            op         <= next_op;
            addr       <= next_addr;
            data       <= next_data;
            step       <= next_step;
            timer      <= next_timer;
            wait_cnt   <= next_wait_cnt;
            bypass     <= next_bypass;
            aborted    <= next_aborted;
            busy_seen  <= next_busy_seen;
            resp_valid <= next_resp_valid;
            byte_mode  <= next_byte_mode;
            alt        <= next_alt;
        end
    end

    flash_bus_cycle u_cycle (
        .core_clk_i       (core_clk_i),
        .reset_n_i        (reset_n_i),
        .start_i          (cyc_start),
        .write_i          (cyc_write),
        .addr_i           (cyc_addr),
        .wdata_i          (cyc_wdata),
        .dq_i             (dq_i),
        .ready_o          (cyc_ready),
        .done_o           (cyc_done),
        .rdata_o          (cyc_rdata),
        .addr_o           (addr_o),
        .dq_o             (bus_dq),
        .dq_oe_o          (dq_oe_o),
        .chip_select_n_o  (chip_select_n_o),
        .output_gate_n_o  (output_gate_n_o),
        .write_strobe_n_o (write_strobe_n_o)
    );

    wire protect_active = (state == H_SEQ || state == H_BUS) && (op == OP_PROTECT);
    assign req_ready_o               = (state == H_IDLE);
    assign resp_valid_o              = resp_valid;
    // Byte mode: only the low lane carries data
    assign resp_data_o               = byte_mode ? {8'h00, cyc_rdata[7:0]} : cyc_rdata;
    assign dq_o                      = byte_mode ? {8'h00, bus_dq[7:0]} : bus_dq;
    assign top_data_or_low_address_o = byte_mode ? addr[0] : bus_dq[15];
    assign width_select_n_o          = !byte_mode;
    assign bypass_active_o           = bypass;
    assign aborted_o                 = aborted;
    assign hardware_clear_n_o        = (state != H_RESET_PULSE);
    assign clear_elevated_o          = protect_active && !alt;
    assign id_voltage_address_elevated_o = protect_active && alt;
    assign output_gate_elevated_o    = protect_active && alt && (step == 3'd0);

    a_clear_pulse_len: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $fell(hardware_clear_n_o) |-> !hardware_clear_n_o [*8])
        else $error("clear pulse too short");
    a_no_bus_in_reset: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !hardware_clear_n_o |-> chip_select_n_o)
        else $error("bus cycle during clear pulse");
    a_recovery_wait: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        $rose(hardware_clear_n_o) |-> chip_select_n_o [*8])
        else $error("access before recovery time");
    a_width_follows: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !chip_select_n_o && !width_select_n_o |-> dq_o[15:8] == 8'h00)
        else $error("upper lane driven in byte mode");
    a_bypass_two_writes: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state == H_BUS && op == OP_BYPASS_PROGRAM && cyc_done && step == 3'd1) |=> resp_valid_o)
        else $error("bypass program not two cycles");
    a_protect_pattern: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        clear_elevated_o && !chip_select_n_o |-> addr_o[6] == 1'b0 && addr_o[1:0] == 2'b10)
        else $error("protect address pattern wrong");
    a_alt_gate: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        output_gate_elevated_o |-> id_voltage_address_elevated_o && !clear_elevated_o)
        else $error("alternate protect pins inconsistent");
    a_ready_bound: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        (state == H_RESET_WAIT) |-> (wait_cnt < READY_CYC))
        else $error("reset wait exceeded ready time");
endmodule : flash_host

/* rtl/flash_host_params.svh */
// Timing counts, pin widths and command codes for the parallel flash host.
// Assumes a 250 MHz core clock (4 ns period).
`ifndef FLASH_HOST_PARAMS_SVH
`define FLASH_HOST_PARAMS_SVH
`define CLK_PERIOD_PS      4000
`define ADDR_W             18
`define DATA_W             16
`define T_ACC_NS           70
`define T_WP_NS            35
`define T_WPH_NS           30
`define T_RP_NS            500
`define T_RH_NS            50
`define T_READY_NS         20000
`define T_ACC_CYC          ((`T_ACC_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_WP_CYC           ((`T_WP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_WPH_CYC          ((`T_WPH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_RP_CYC           ((`T_RP_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_RH_CYC           ((`T_RH_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define T_READY_CYC        ((`T_READY_NS * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS)
`define UNLOCK1_ADDR       18'h00555
`define UNLOCK2_ADDR       18'h002AA
`define UNLOCK1_DATA       16'h00AA
`define UNLOCK2_DATA       16'h0055
`define CMD_PROGRAM        16'h00A0
`define CMD_BYPASS_ENTER   16'h0020
`define CMD_ERASE_SETUP    16'h0080
`define CMD_SECTOR_ERASE   16'h0030
`define CMD_CHIP_ERASE     16'h0010
`define CMD_IDENTIFY       16'h0090
`define CMD_READ_RESET     16'h00F0
`define PROT_ADDR_MASK     18'h00043
`define PROT_ADDR_VALUE    18'h00002
`endif

/* rtl/flash_host_pkg.sv */
// Types shared by the parallel flash host files.
// Assumes nothing of its surroundings.
package flash_host_pkg;
    typedef enum logic [3:0] {
        OP_READ,
        OP_WRITE,
        OP_PROGRAM,
        OP_BYPASS_PROGRAM,
        OP_BYPASS_ENTER,
        OP_SECTOR_ERASE,
        OP_SECTOR_ERASE_MORE,
        OP_CHIP_ERASE,
        OP_IDENTIFY,
        OP_READ_RESET,
        OP_HW_RESET,
        OP_PROTECT
    } host_op_e;
    typedef logic [17:0] flash_addr_t;
    typedef logic [15:0] flash_data_t;
endpackage : flash_host_pkg

/* rtl/flash_bus_cycle.sv */
// One read or write bus cycle on the flash pins, timed by cycle counts.
// Assumes the caller holds start_i only while ready_o is high.
`timescale 1ns/1ps
`include "flash_host_params.svh"
module flash_bus_cycle (
    input  wire logic                      core_clk_i,
    input  wire logic                      reset_n_i,
    input  wire logic                      start_i,
    input  wire logic                      write_i,
    input  wire flash_host_pkg::flash_addr_t addr_i,
    input  wire flash_host_pkg::flash_data_t wdata_i,
    input  wire flash_host_pkg::flash_data_t dq_i,
    output logic                           ready_o,
    output logic                           done_o,
    output flash_host_pkg::flash_data_t    rdata_o,
    output flash_host_pkg::flash_addr_t    addr_o,
    output flash_host_pkg::flash_data_t    dq_o,
    output logic                           dq_oe_o,
    output logic                           chip_select_n_o,
    output logic                           output_gate_n_o,
    output logic                           write_strobe_n_o
);
    import flash_host_pkg::*;
    typedef enum logic [1:0] {CY_IDLE, CY_ACTIVE, CY_RECOVER} cyc_state_e;
    localparam logic [7:0] ACC_CYC = 8'(`T_ACC_CYC);
    localparam logic [7:0] WP_CYC  = 8'(`T_WP_CYC);
    localparam logic [7:0] WPH_CYC = 8'(`T_WPH_CYC);

    cyc_state_e  state, next_state;
    logic [7:0]  count, next_count;
    logic        wr, next_wr;
    flash_data_t rdata, next_rdata;
    flash_addr_t addr, next_addr;
    flash_data_t wdata, next_wdata;

    always_comb begin
        next_state = state;
        next_count = count;
        next_wr    = wr;
        next_rdata = rdata;
        next_addr  = addr;
        next_wdata = wdata;
        done_o     = 1'b0;
        case (state)
            CY_IDLE: begin
                if (start_i) begin
                    next_state = CY_ACTIVE;
                    next_wr    = write_i;
                    next_addr  = addr_i;
                    next_wdata = wdata_i;
                    next_count = write_i ? WP_CYC : ACC_CYC;
                end
            end
            CY_ACTIVE: begin
                if (count > 8'h01) begin
                    next_count = count - 8'h01;
                end else begin
                    if (!wr) begin
                        next_rdata = dq_i;
                    end
                    next_state = CY_RECOVER;
                    next_count = WPH_CYC;
                end
            end
            default: begin
                if (count > 8'h01) begin
                    next_count = count - 8'h01;
                end else begin
                    next_state = CY_IDLE;
                    done_o     = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!reset_n_i) begin
            state <= CY_IDLE;
            count <= 8'h00;
            wr    <= 1'b0;
            rdata <= 16'h0000;
            addr  <= 18'h00000;
            wdata <= 16'h0000;
        end else begin
            state <= next_state;
            count <= next_count;
            wr    <= next_wr;
            rdata <= next_rdata;
            addr  <= next_addr;
            wdata <= next_wdata;
        end
    end

    assign ready_o          = (state == CY_IDLE);
    assign rdata_o          = rdata;
    assign addr_o           = addr;
    assign dq_o             = wdata;
    assign dq_oe_o          = (state == CY_ACTIVE) && wr;
    assign chip_select_n_o  = !(state == CY_ACTIVE);
    // Read: select and gate low, strobe high; write: select and strobe low, gate high
    assign output_gate_n_o  = !((state == CY_ACTIVE) && !wr);
    assign write_strobe_n_o = !((state == CY_ACTIVE) && wr);

    a_strobe_gate_exclusive: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !(!write_strobe_n_o && !output_gate_n_o))
        else $error("write strobe and output gate both low");
    a_write_cs_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !write_strobe_n_o |-> !chip_select_n_o)
        else $error("write strobe low without chip select");
    a_read_cs_low: assert property (@(posedge core_clk_i) disable iff (!reset_n_i)
        !output_gate_n_o |-> !chip_select_n_o && write_strobe_n_o && !dq_oe_o)
        else $error("read cycle pins wrong");
endmodule : flash_bus_cycle

/* tb/flash_model.sv */
// Behavioural parallel flash facing flash_host.
// Assumes the bench clock; lines it does not drive show the inverse.
`timescale 1ns/1ps
module flash_model #(
    parameter logic [7:0] MAKER_ID = 8'h5E  // Arbitrary value
) (
    input  wire logic        clk_i,
    input  wire logic [17:0] addr_i,
    input  wire logic        low_addr_i,
    input  wire logic        cs_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        wide_i,
    input  wire logic        clr_n_i,
    input  wire logic        prot_i,
    input  wire logic [15:0] din_i,
    output logic [15:0]      dq_o,
    output logic             busy_n_o,
    output int               wr_cnt,
    output logic [15:0]      last_wr
);
    logic        id_mode = 0, prog_next = 0, we_q = 1, cs_q = 1, locked = 0;
    logic [15:0] rd, wdat;
    int          busy = 0;
    initial wr_cnt = 0;
    always_comb begin
        rd = id_mode ? {8'h00, MAKER_ID} : addr_i[15:0] ^ 16'h3C5A;
        if (!wide_i && !id_mode) rd = {~rd[15:8], 7'h2A, low_addr_i};
        dq_o = (!cs_n_i && !oe_n_i && we_n_i && clr_n_i) ? rd : ~rd;
    end
    assign busy_n_o = (busy == 0);
    always @(posedge clk_i) begin
        we_q <= we_n_i;
        cs_q <= cs_n_i;
        if (busy > 0) busy <= busy - 1;
        if (!we_n_i && !cs_n_i) wdat <= din_i;
        if (!clr_n_i) begin
            id_mode <= 0;
            prog_next <= 0;
            if (busy > 50) busy <= 50;
        end else if (we_n_i && !we_q && !cs_q && oe_n_i) begin
            wr_cnt <= wr_cnt + 1;
            last_wr <= wdat;
            if (prog_next && !locked) busy <= 1000;
            if (prot_i) locked <= 1;
            prog_next <= wdat[7:0] == 8'hA0;
            if (wdat[7:0] == 8'h90) id_mode <= 1;
            if (wdat[7:0] == 8'hF0) id_mode <= 0;
        end
    end
endmodule : flash_model

/* tb/flash_host_tb.sv */
// Self-checking bench for flash_host with a behavioural flash.
// Assumes flash_model from the bench folder.
`timescale 1ns/1ps
module flash_host_tb;
    import flash_host_pkg::*;
    logic        core_clk_i = 0, reset_n_i = 0, req_valid_i = 0, byte_mode_i = 0;
    logic        req_ready_o, resp_valid_o, bypass_active_o, aborted_o, top_data_or_low_address_o, dq_oe_o;
    logic        chip_select_n_o, output_gate_n_o, write_strobe_n_o, width_select_n_o, hardware_clear_n_o;
    logic        ready_busy_n_i, clear_elevated_o, id_voltage_address_elevated_o, output_gate_elevated_o;
    logic        protect_alt_i = 0;
    logic [2:0]  elev;
    host_op_e    req_op_i = OP_READ;
    flash_addr_t req_addr_i = '0, addr_o, wr_addr;
    flash_data_t req_data_i = '0, resp_data_o, dq_o, dev_dq, last_wr;
    int          error_cnt = 0, num_checks = 0, wr_cnt, w0;
    wire flash_data_t dq_i = dq_oe_o ? dq_o : dev_dq;
    flash_host DUT (.core_clk_i, .reset_n_i, .req_valid_i, .req_ready_o, .req_op_i, .req_addr_i, .req_data_i,
        .byte_mode_i, .protect_alt_i, .resp_valid_o, .resp_data_o, .bypass_active_o, .aborted_o, .addr_o,
        .top_data_or_low_address_o, .dq_i, .dq_o, .dq_oe_o, .chip_select_n_o, .output_gate_n_o, .write_strobe_n_o,
        .width_select_n_o, .hardware_clear_n_o, .clear_elevated_o, .id_voltage_address_elevated_o,
        .output_gate_elevated_o, .ready_busy_n_i);
    flash_model #(.MAKER_ID(8'h5E)) flash (.clk_i(core_clk_i), .addr_i(addr_o), .low_addr_i(top_data_or_low_address_o),
        .cs_n_i(chip_select_n_o), .oe_n_i(output_gate_n_o), .we_n_i(write_strobe_n_o), .wide_i(width_select_n_o),
        .clr_n_i(hardware_clear_n_o), .prot_i(clear_elevated_o), .din_i(dq_o), .dq_o(dev_dq),
        .busy_n_o(ready_busy_n_i), .wr_cnt, .last_wr);
    initial forever #2 core_clk_i = ~core_clk_i;
    // Elevated-pin levels and address seen during the latest write strobe
    always @(posedge core_clk_i) if (!write_strobe_n_o) begin
        elev <= {clear_elevated_o, id_voltage_address_elevated_o, output_gate_elevated_o};
        wr_addr <= addr_o;
    end
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic req(input host_op_e op, input flash_addr_t a, input logic bm);
        int n = 0;
        do begin @(posedge core_clk_i); #1; end while (req_ready_o !== 1'b1);
        req_op_i = op;
        req_addr_i = a;
        byte_mode_i = bm;
        req_valid_i = 1;
        @(posedge core_clk_i); #1;
        req_valid_i = 0;
        while (resp_valid_o !== 1'b1 && n < 6000) begin @(posedge core_clk_i); #1; n++; end
        chk("resp_valid", 16'h1, 16'(resp_valid_o));
    endtask : req
    task automatic t_reads;
        req(OP_READ, 18'h01234, 0);
        chk("word", 16'h1234 ^ 16'h3C5A, resp_data_o);
        req(OP_READ, 18'h00007, 1);
        chk("byte odd", 16'h0055, resp_data_o);
        req(OP_READ, 18'h00006, 1);
        chk("byte even", 16'h0054, resp_data_o);
        $display("reads done");
    endtask : t_reads
    task automatic t_ident;
        req(OP_IDENTIFY, 18'h0, 0);
        req(OP_READ, 18'h0, 0);
        chk("id", 16'h005E, resp_data_o);
        req(OP_READ_RESET, 18'h0, 0);
        req(OP_READ, 18'h00010, 0);
        chk("array", 16'h0010 ^ 16'h3C5A, resp_data_o);
        $display("identify done");
    endtask : t_ident
    task automatic t_prog;
        w0 = wr_cnt;
        req_data_i = 16'h1357;
        req(OP_PROGRAM, 18'h00100, 0);
        chk("writes", 16'd4, 16'(wr_cnt - w0));
        chk("data", 16'h1357, last_wr);
        req(OP_BYPASS_ENTER, 18'h0, 0);
        chk("bypass", 16'h1, 16'(bypass_active_o));
        w0 = wr_cnt;
        req(OP_BYPASS_PROGRAM, 18'h00102, 0);
        chk("bp writes", 16'd2, 16'(wr_cnt - w0));
        req(OP_HW_RESET, 18'h0, 0);
        chk("aborted", 16'h1, 16'(aborted_o));
        chk("bypass off", 16'h0, 16'(bypass_active_o));
        req(OP_READ, 18'h00020, 0);
        chk("after reset", 16'h0020 ^ 16'h3C5A, resp_data_o);
        req(OP_HW_RESET, 18'h0, 0);
        chk("idle reset", 16'h0, 16'(aborted_o));
        $display("program done");
    endtask : t_prog
    task automatic t_erase;
        w0 = wr_cnt;
        req(OP_CHIP_ERASE, 18'h0, 0);
        chk("chip erase", 16'h0010, last_wr);
        req(OP_SECTOR_ERASE, 18'h04000, 0);
        req(OP_SECTOR_ERASE_MORE, 18'h08000, 0);
        chk("erase writes", 16'd13, 16'(wr_cnt - w0));
        chk("sector erase", 16'h0030, last_wr);
        chk("sector addr", 16'h8000, wr_addr[15:0]);
        req_data_i = 16'h0000;
        req(OP_PROTECT, 18'h3FFFF, 0);
        chk("protect pins", 16'h0004, 16'(elev));
        chk("protect addr", 16'hFFBE, wr_addr[15:0]);
        protect_alt_i = 1;
        req(OP_PROTECT, 18'h3FFFF, 0);
        protect_alt_i = 0;
        chk("alt pins", 16'h0003, 16'(elev));
        req(OP_PROGRAM, 18'h00100, 0);
        req(OP_HW_RESET, 18'h0, 0);
        chk("refused", 16'h0, 16'(aborted_o));
        $display("erase and protect done");
    endtask : t_erase
    task automatic end_of_test;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_of_test
    initial begin
        repeat (60000) @(posedge core_clk_i);
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge core_clk_i);
        #1 reset_n_i = 1;
        t_reads;
        t_ident;
        t_prog;
        t_erase;
        end_of_test;
    end
endmodule : flash_host_tb
